//--- hdl/rxfs_flywheel.sv
// Purpose: frame flywheel, tracks bit position and checks frame sync timing
// Assumes: serial_clk_rise marks one received bit
// Notes: bit_pos is combinational and valid in the cycle of serial_clk_rise
`timescale 1ns/1ps
`default_nettype none
module rxfs_flywheel (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  rxfs_link_if.fly lnk
);
  logic [9:0] cnt_reg;
  logic prev_sync_reg;
  logic locked_reg;
  wire logic tdm_mode = (lnk.port_mode == rxfs_pkg::MODE_T1) ||
                        (lnk.port_mode == rxfs_pkg::MODE_E1) ||
                        (lnk.port_mode == rxfs_pkg::MODE_2E1) ||
                        (lnk.port_mode == rxfs_pkg::MODE_4E1);
  wire logic [9:0] frame_last =
    (lnk.port_mode == rxfs_pkg::MODE_T1) ? rxfs_pkg::FRAME_LAST_T1 :
    (lnk.port_mode == rxfs_pkg::MODE_E1) ? rxfs_pkg::FRAME_LAST_E1 :
    (lnk.port_mode == rxfs_pkg::MODE_2E1) ? rxfs_pkg::FRAME_LAST_2E1 :
    rxfs_pkg::FRAME_LAST_4E1;
  // sync is judged on link clock edges, as the line interface presents it
  wire logic sync_edge = lnk.serial_clk_rise && lnk.frame_sync_lvl && !prev_sync_reg;
  // sync bit is time slot 0 bit 0
  wire logic [9:0] pos = sync_edge ? 10'h000 : cnt_reg;
  wire logic [9:0] pos_inc = pos + 10'h001;
  wire logic [9:0] cnt_next = (pos >= frame_last) ? 10'h000 : pos_inc;
  // expected only when the counter has just wrapped to slot 0
  assign lnk.frame_alignment_change_error = sync_edge && tdm_mode && locked_reg && (cnt_reg != 10'h000);
  assign lnk.locked = locked_reg;
  assign lnk.bit_pos = pos;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 10'h000;
      prev_sync_reg <= 1'b0;
      locked_reg <= 1'b0;
    end else if (clk_en) begin
      if (!tdm_mode) begin
        locked_reg <= 1'b0;
      end else if (sync_edge) begin
        locked_reg <= 1'b1;
      end
      if (lnk.serial_clk_rise) begin
        prev_sync_reg <= lnk.frame_sync_lvl;
        cnt_reg <= cnt_next;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/rxfs_link_if.sv
// Purpose: carries sampled link timing between the top and the flywheel
// Assumes: all signals are on mclk
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface rxfs_link_if;
  logic serial_clk_rise;
  logic frame_sync_lvl;
  logic [2:0] port_mode;
  logic frame_alignment_change_error;
  logic locked;
  logic [9:0] bit_pos;
  modport top (
    output serial_clk_rise,
    output frame_sync_lvl,
    output port_mode,
    input frame_alignment_change_error,
    input locked,
    input bit_pos
  );
  modport fly (
    input serial_clk_rise,
    input frame_sync_lvl,
    input port_mode,
    output frame_alignment_change_error,
    output locked,
    output bit_pos
  );
endinterface
`default_nettype wire

//--- hdl/rxfs_pkg.sv
// Purpose: constants for the receive frame-sync error handler
// Assumes: register index n sits at byte address 4*n on the register bus
// Notes: rule summary below; all offsets, fields, codes and frame lengths live here
//
// Summary of operation
// - alignment change is checked only in T1, E1, 2xE1 and 4xE1 port modes.
// - a frame sync rise that the flywheel does not expect flags alignment change.
// - frame sync marks time slot 0; bit positions map from that point.
// - an alignment change acts on every active channel of the group.
// - alignment change queues a descriptor with its error code, receive direction.
// - abort bit 0: channels keep sampling and passing bits after alignment change.
// - abort bit 1: alignment change suspends receive and discards the bits.
// - loss of frame queues a descriptor with its error code, receive direction.
// - loss of frame flushes the internal receive FIFO contents.
// - abort bit 0: during loss of frame pass all-ones, resume on recovery.
// - abort bit 1: loss of frame suspends receive, nothing is transferred.
// - frame-check field 1 with protocol field 2 selects intersystem link protocol.
// - out-of-frame to in-frame queues a recovery event, gated by the group mask.
package rxfs_pkg;
  // register word indices
  localparam logic [2:0] ADDR_GROUP_CFG = 3'h0;
  localparam logic [2:0] ADDR_CHAN_CFG = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
  localparam logic [2:0] ADDR_STATE = 3'h4;
  localparam logic [2:0] ADDR_LAST_DESC = 3'h5;
  // group configuration fields
  localparam int GCFG_MODE_LSB = 0;
  localparam int GCFG_ABORT_BIT = 3;
  localparam int GCFG_MASK_BIT = 4;
  localparam int GCFG_REACT_BIT = 5;
  localparam logic [4:0] GCFG_RESET = 5'h00;
  // channel configuration fields
  localparam int CCFG_FCS_LSB = 0;
  localparam int CCFG_PROTO_LSB = 2;
  localparam logic [4:0] CCFG_RESET = 5'h00;
  localparam logic [1:0] FCS_ISL = 2'h1;
  localparam logic [2:0] PROTO_ISL = 3'h2;
  // event bits in status, mask and pending vectors
  localparam int EV_FRAME_ALIGNMENT_CHANGE_ERROR = 0;
  localparam int EV_OOF = 1;
  localparam int EV_FRAME_RECOVERY_EVENT = 2;
  localparam logic [2:0] EV_NONE = 3'h0;
  // port modes
  localparam logic [2:0] MODE_OTHER = 3'h0;
  localparam logic [2:0] MODE_T1 = 3'h1;
  localparam logic [2:0] MODE_E1 = 3'h2;
  localparam logic [2:0] MODE_2E1 = 3'h3;
  localparam logic [2:0] MODE_4E1 = 3'h4;
  // last bit position of a frame per mode
  localparam logic [9:0] FRAME_LAST_T1 = 10'h0c0;
  localparam logic [9:0] FRAME_LAST_E1 = 10'h0ff;
  localparam logic [9:0] FRAME_LAST_2E1 = 10'h1ff;
  localparam logic [9:0] FRAME_LAST_4E1 = 10'h3ff;
  // descriptor: [4:0] code, [5] direction, [6] event (not error)
  localparam logic [4:0] CODE_FRAME_ALIGNMENT_CHANGE_ERROR = 5'h0a;
  localparam logic [4:0] CODE_OOF = 5'h0b;
  localparam logic [4:0] CODE_FRAME_RECOVERY_EVENT = 5'h01;
  localparam logic DIR_RX = 1'b0;
  localparam logic [6:0] DESC_RESET = 7'h00;
  typedef enum logic [1:0] {
    RX_ACTIVE = 2'b00,
    RX_ONES = 2'b01,
    RX_SUSPENDED = 2'b10
  } rxfs_rx_state_t;
endpackage

//--- hdl/rxfs_sync.sv
// Purpose: three-flop synchroniser with agreement filter and edge pulses
// Assumes: inputs are asynchronous to mclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rxfs_sync #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] lvl,
  output var logic [W-1:0] rise,
  output var logic [W-1:0] fall
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      wire logic agree = (s2_reg == s3_reg);
      wire logic change = agree && (s3_reg != lvl[i]);
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl[i] <= 1'b0;
          rise[i] <= 1'b0;
          fall[i] <= 1'b0;
        end else if (clk_en) begin
          s1_reg <= async_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (change) begin
            lvl[i] <= s3_reg;
          end
          rise[i] <= change && s3_reg;
          fall[i] <= change && !s3_reg;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- hdl/rxfs_top.sv
// Purpose: receive frame-sync error handling for one serial port group
// Assumes: link pins are asynchronous, link clock far slower than mclk
// Notes: register bus is Avalon-MM with waitrequest, word index addressing
`timescale 1ns/1ps
`default_nettype none
module rxfs_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output var logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_serial_clk,
  input wire logic rx_frame_sync,
  input wire logic rx_data,
  input wire logic rx_out_of_frame,
  output var logic desc_valid,
  input wire logic desc_ready,
  output var logic [6:0] desc_data,
  output var logic rx_bit_valid,
  output var logic rx_bit,
  output var logic [6:0] rx_slot,
  output var logic [2:0] rx_bit_idx,
  output var logic rx_fifo_flush,
  output var logic rx_active,
  output var logic isl_mode,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////////
  // link sampling
  logic [3:0] pin_lvl;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  rxfs_link_if lnk ();

  rxfs_sync #(
    .W(4)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .clk_en(clk_en),
    .async_in({rx_out_of_frame, rx_data, rx_frame_sync, rx_serial_clk}),
    .lvl(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  rxfs_flywheel u_fly (
    .mclk(mclk),
    .resetn(resetn),
    .clk_en(clk_en),
    .lnk(lnk)
  );

  wire logic clk_rise = pin_rise[0];
  wire logic data_lvl = pin_lvl[2];
  wire logic oof_lvl = pin_lvl[3];
  wire logic oof_rise = pin_rise[3];
  wire logic oof_fall = pin_fall[3];

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0] group_cfg_reg;
  logic [4:0] chan_cfg_reg;
  logic [2:0] status_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] pend_reg;
  logic ack_reg;
  rxfs_pkg::rxfs_rx_state_t state_reg;
  rxfs_pkg::rxfs_rx_state_t state_next;

  assign lnk.serial_clk_rise = clk_rise;
  assign lnk.frame_sync_lvl = pin_lvl[1];
  assign lnk.port_mode = group_cfg_reg[rxfs_pkg::GCFG_MODE_LSB +: 3];

  // one setting for the whole group, shared by every channel on the port
  wire logic abort_on_frame_loss = group_cfg_reg[rxfs_pkg::GCFG_ABORT_BIT];
  wire logic mask_frame_loss_events = group_cfg_reg[rxfs_pkg::GCFG_MASK_BIT];
  wire logic [1:0] fcs_field = chan_cfg_reg[rxfs_pkg::CCFG_FCS_LSB +: 2];
  wire logic [2:0] proto_field = chan_cfg_reg[rxfs_pkg::CCFG_PROTO_LSB +: 3];
  wire logic intersystem_link_proto = (fcs_field == rxfs_pkg::FCS_ISL) &&
                                      (proto_field == rxfs_pkg::PROTO_ISL);

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer in the second cycle of a request
  wire logic req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_reg;
  wire logic do_write = avs_write && ack_reg;
  wire logic do_read = avs_read && ack_reg;
  wire logic wr_group = do_write && (avs_address == rxfs_pkg::ADDR_GROUP_CFG);
  wire logic wr_chan = do_write && (avs_address == rxfs_pkg::ADDR_CHAN_CFG);
  wire logic wr_mask = do_write && (avs_address == rxfs_pkg::ADDR_IRQ_MASK);
  wire logic rd_status = do_read && (avs_address == rxfs_pkg::ADDR_STATUS);
  wire logic reactivate = wr_group && avs_writedata[rxfs_pkg::GCFG_REACT_BIT];
  wire logic [31:0] state_word = {18'h00000, rx_slot, 2'h0, intersystem_link_proto,
                                  lnk.locked, oof_lvl, state_reg};
  wire logic [31:0] rd_mux =
    (avs_address == rxfs_pkg::ADDR_GROUP_CFG) ? {27'h0000000, group_cfg_reg} :
    (avs_address == rxfs_pkg::ADDR_CHAN_CFG) ? {27'h0000000, chan_cfg_reg} :
    (avs_address == rxfs_pkg::ADDR_STATUS) ? {29'h00000000, status_reg} :
    (avs_address == rxfs_pkg::ADDR_IRQ_MASK) ? {29'h00000000, irq_mask_reg} :
    (avs_address == rxfs_pkg::ADDR_STATE) ? state_word :
    (avs_address == rxfs_pkg::ADDR_LAST_DESC) ? {25'h0000000, desc_data} :
    32'h00000000;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (clk_en) begin
      ack_reg <= req && !ack_reg;
      if (avs_read && !ack_reg) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      group_cfg_reg <= rxfs_pkg::GCFG_RESET;
      chan_cfg_reg <= rxfs_pkg::CCFG_RESET;
      irq_mask_reg <= rxfs_pkg::EV_NONE;
    end else if (clk_en) begin
      if (wr_group) begin
        group_cfg_reg <= avs_writedata[4:0];
      end
      if (wr_chan) begin
        chan_cfg_reg <= avs_writedata[4:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= avs_writedata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // events
  wire logic ev_frame_alignment_change_error = lnk.frame_alignment_change_error;
  wire logic [2:0] ev_set = {oof_fall, oof_rise, ev_frame_alignment_change_error};
  // recovery descriptor is dropped when the group masks frame loss events
  wire logic [2:0] ev_queue = {oof_fall && !mask_frame_loss_events,
                               oof_rise, ev_frame_alignment_change_error};
  // only bits shown by the read are cleared; later events survive
  wire logic [2:0] status_clr = rd_status ? avs_readdata[2:0] : rxfs_pkg::EV_NONE;
  wire logic [2:0] status_next = (status_reg & ~status_clr) | ev_set;
  assign irq = |(status_reg & irq_mask_reg);

  // descriptor queue: loss of frame first, then alignment change, then recovery
  wire logic slot_free = !desc_valid || desc_ready;
  wire logic pick_oof = pend_reg[rxfs_pkg::EV_OOF];
  wire logic pick_frame_alignment_change_error = !pick_oof && pend_reg[rxfs_pkg::EV_FRAME_ALIGNMENT_CHANGE_ERROR];
  wire logic pick_frame_recovery_event = !pick_oof && !pick_frame_alignment_change_error && pend_reg[rxfs_pkg::EV_FRAME_RECOVERY_EVENT];
  wire logic load_desc = slot_free && (|pend_reg);
  wire logic [2:0] taken = load_desc ? {pick_frame_recovery_event, pick_oof, pick_frame_alignment_change_error} : rxfs_pkg::EV_NONE;
  wire logic [2:0] pend_next = (pend_reg & ~taken) | ev_queue;
  wire logic [4:0] pick_code = pick_oof ? rxfs_pkg::CODE_OOF :
                               pick_frame_alignment_change_error ? rxfs_pkg::CODE_FRAME_ALIGNMENT_CHANGE_ERROR : rxfs_pkg::CODE_FRAME_RECOVERY_EVENT;
  wire logic [6:0] desc_next = {pick_frame_recovery_event, rxfs_pkg::DIR_RX, pick_code};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= rxfs_pkg::EV_NONE;
      pend_reg <= rxfs_pkg::EV_NONE;
      desc_valid <= 1'b0;
      desc_data <= rxfs_pkg::DESC_RESET;
    end else if (clk_en) begin
      status_reg <= status_next;
      pend_reg <= pend_next;
      if (load_desc) begin
        desc_valid <= 1'b1;
        desc_data <= desc_next;
      end else if (desc_ready) begin
        desc_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive channel state, one state for the whole group
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rxfs_pkg::RX_ACTIVE: begin
        if (oof_rise) begin
          state_next = abort_on_frame_loss ? rxfs_pkg::RX_SUSPENDED
                                           : rxfs_pkg::RX_ONES;
        end else if (ev_frame_alignment_change_error && abort_on_frame_loss) begin
          state_next = rxfs_pkg::RX_SUSPENDED;
        end
      end
      rxfs_pkg::RX_ONES: begin
        if (oof_fall) begin
          state_next = rxfs_pkg::RX_ACTIVE;
        end else if (ev_frame_alignment_change_error && abort_on_frame_loss) begin
          state_next = rxfs_pkg::RX_SUSPENDED;
        end
      end
      rxfs_pkg::RX_SUSPENDED: begin
        // reactivation while still out of frame is ignored
        if (reactivate && !oof_lvl) begin
          state_next = rxfs_pkg::RX_ACTIVE;
        end
      end
      default: begin
        state_next = rxfs_pkg::RX_SUSPENDED;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // received bit stream
  // bits seen in the event cycle that suspends are already discarded
  wire logic kill_bit = abort_on_frame_loss && (ev_frame_alignment_change_error || oof_lvl);
  wire logic pass_bit = clk_rise && (state_reg != rxfs_pkg::RX_SUSPENDED) && !kill_bit;
  wire logic ones_fill = (state_reg == rxfs_pkg::RX_ONES) || oof_lvl;
  wire logic bit_next = ones_fill ? 1'b1 : data_lvl;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= rxfs_pkg::RX_ACTIVE;
      rx_bit_valid <= 1'b0;
      rx_bit <= 1'b0;
      rx_slot <= 7'h00;
      rx_bit_idx <= 3'h0;
      rx_fifo_flush <= 1'b0;
      rx_active <= 1'b1;
      isl_mode <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      rx_bit_valid <= pass_bit;
      if (pass_bit) begin
        rx_bit <= bit_next;
        rx_slot <= lnk.bit_pos[9:3];
        rx_bit_idx <= lnk.bit_pos[2:0];
      end
      rx_fifo_flush <= oof_rise;
      rx_active <= (state_next != rxfs_pkg::RX_SUSPENDED);
      isl_mode <= intersystem_link_proto;
    end
  end
endmodule
`default_nettype wire

//--- verif/rxfs_chk.sv
// Purpose: port-level assertions for rxfs_top
// Assumes: clk_en held high by the bench
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module rxfs_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rx_out_of_frame,
  input wire logic desc_valid,
  input wire logic [6:0] desc_data,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_fifo_flush,
  input wire logic rx_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_wait_one:
  assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus late");
  a_desc_dir:
  assert property (desc_valid |-> !desc_data[5]) else $error("descriptor not receive");
  a_desc_kind:
  assert property (desc_valid |-> (desc_data[6] ? desc_data[4:0] == 5'h01
    : desc_data[4:0] inside {5'h0a, 5'h0b})) else $error("bad descriptor code");
  a_oof_flush:
  assert property ($rose(rx_out_of_frame) |-> ##[2:8] rx_fifo_flush) else $error("no flush");
  a_oof_desc:
  assert property (rx_fifo_flush |-> ##[1:3] (desc_valid && desc_data[4:0] == 5'h0b))
    else $error("no out of frame descriptor");
  a_ones_fill:
  assert property (rx_bit_valid && rx_out_of_frame && $past(rx_out_of_frame, 8) |-> rx_bit)
    else $error("zero passed out of frame");
  a_susp_quiet:
  assert property (!rx_active ##1 !rx_active |-> !rx_bit_valid) else $error("bit while suspended");
  a_bit_pulse:
  assert property (rx_bit_valid |=> !rx_bit_valid) else $error("bit pulse too long");
  cover property (rx_fifo_flush);
  cover property (desc_valid && desc_data == 7'h41);
  cover property ($fell(rx_active));
endmodule
bind rxfs_top rxfs_chk chk_u (.*);
`default_nettype wire

//--- verif/rxfs_line_model.sv
// Purpose: line interface model feeding clock, frame sync, data and out-of-frame
// Assumes: T1 framing, data is 0 only at slot 0 bit 0
// Notes: clock stands still while run is low
`timescale 1ns/1ps
`default_nettype none
module rxfs_line_model #(
  parameter int FRAME_BITS = int'(rxfs_pkg::FRAME_LAST_T1) + 1
) (
  input wire logic run,
  input wire logic slip,
  input wire logic oof_req,
  output var logic rx_serial_clk,
  output var logic rx_frame_sync,
  output var logic rx_data,
  output var logic rx_out_of_frame
);
  int pos = 0;
  // pins change while the clock is low, so every rise sees settled levels
  initial begin
    rx_serial_clk = 1'b0;
    rx_frame_sync = 1'b0;
    rx_data = 1'b1;
    rx_out_of_frame = 1'b0;
    forever begin
      #400;
      rx_serial_clk = 1'b0;
      rx_out_of_frame = oof_req;
      if (run) begin
        pos = (slip || pos == FRAME_BITS - 1) ? 0 : pos + 1;
        rx_frame_sync = (pos == 0);
        rx_data = (pos != 0);
        #400;
        rx_serial_clk = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/rxfs_top_test.sv
// Purpose: self-checking bench for rxfs_top
// Assumes: clk_en and desc_ready tied high
// Notes: bit and descriptor monitors feed the checks
`timescale 1ns/1ps
`default_nettype none
module rxfs_top_test;
  logic mclk = 1'b0, resetn = 1'b0, clk_en = 1'b1, desc_ready = 1'b1;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rv;
  logic avs_waitrequest, rx_serial_clk, rx_frame_sync, rx_data, rx_out_of_frame;
  logic desc_valid, rx_bit_valid, rx_bit, rx_fifo_flush, rx_active, isl_mode, irq;
  logic [6:0] desc_data, rx_slot;
  logic [2:0] rx_bit_idx;
  logic run = 1'b0, slip = 1'b0, oof_req = 1'b0, chk_map = 1'b0;
  int n_mismatch = 0, cmp_count = 0, nbits = 0, nzero = 0, nbad = 0, nflush = 0, i, k;
  logic [6:0] dq[$];
  rxfs_top dut_u (.*);
  rxfs_line_model line_u (.*);
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    if (desc_valid === 1'b1 && desc_ready) dq.push_back(desc_data);
    if (rx_fifo_flush === 1'b1) nflush++;
    if (rx_bit_valid === 1'b1) begin
      nbits++;
      if (rx_bit !== 1'b1) nzero++;
      if (chk_map && (rx_bit !== !(rx_slot == 7'h00 && rx_bit_idx == 3'h0))) nbad++;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic to_out;
    n_mismatch++;
    $display("ERROR %0t wait ran out", $time);
    complete_run();
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      if (++t > 20) to_out();
      @(posedge mclk);
    end
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic wait_desc(input logic [6:0] exp);
    int t;
    t = 0;
    while (dq.size() == 0) begin
      if (++t > 4000) to_out();
      @(posedge mclk);
    end
    chk({25'h0, dq.pop_front()}, {25'h0, exp});
  endtask
  task automatic wait_bits(input int n);
    repeat (n * 8) @(posedge mclk);
  endtask
  task automatic do_slip;
    slip <= 1'b1;
    repeat (8) @(posedge mclk);
    slip <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 8; i++) rdchk(3'(i), 32'h0); // reset values, 6 and 7 unmapped
    bus(1'b1, 3'h1, 32'h09);
    rdchk(3'h1, 32'h09);
    chk(32'(isl_mode), 32'h1);
    bus(1'b1, 3'h1, 32'h05);
    rdchk(3'h1, 32'h05);
    chk(32'(isl_mode), 32'h0);
    bus(1'b1, 3'h3, 32'h07);
    bus(1'b1, 3'h0, 32'h01);
    run <= 1'b1;
    wait_bits(250);
    chk_map <= 1'b1;
    wait_bits(400);
    rdchk(3'h2, 32'h0);
    chk(nbad, 0);
    chk(32'(nzero > 1), 32'h1);
    do_slip();
    wait_desc(7'h0a);
    chk(32'(irq), 32'h1);
    rdchk(3'h2, 32'h1);
    chk(32'(irq), 32'h0);
    k = nbits;
    wait_bits(20);
    chk(32'(rx_active), 32'h1);
    chk(32'(nbits > k + 15), 32'h1);
    bus(1'b1, 3'h0, 32'h09);
    do_slip();
    wait_desc(7'h0a);
    wait_bits(2);
    chk(32'(rx_active), 32'h0);
    k = nbits;
    wait_bits(30);
    chk(nbits, k);
    bus(1'b1, 3'h0, 32'h29);
    wait_bits(1);
    chk(32'(rx_active), 32'h1);
    rdchk(3'h2, 32'h1);
    rdchk(3'h0, 32'h09);
    chk(nbad, 0);
    chk_map <= 1'b0;
    bus(1'b1, 3'h0, 32'h00);
    do_slip();
    wait_bits(20);
    rdchk(3'h2, 32'h0);
    chk(dq.size(), 0);
    // a T1-framed line looks misaligned to every wider frame mode
    for (i = 2; i < 5; i++) begin
      bus(1'b1, 3'h0, 32'(i));
      wait_desc(7'h0a);
      bus(1'b1, 3'h0, 32'h00);
    end
    rdchk(3'h2, 32'h1);
    bus(1'b1, 3'h0, 32'h01);
    wait_bits(250);
    k = nflush;
    oof_req <= 1'b1;
    wait_desc(7'h0b);
    chk(nflush, k + 1);
    k = nzero;
    i = nbits;
    wait_bits(250);
    chk(nzero, k);
    chk(32'(nbits > i + 200), 32'h1);
    oof_req <= 1'b0;
    wait_desc(7'h41);
    wait_bits(250);
    chk(32'(nzero > k), 32'h1);
    bus(1'b1, 3'h0, 32'h09);
    oof_req <= 1'b1;
    wait_desc(7'h0b);
    wait_bits(1);
    chk(32'(rx_active), 32'h0);
    k = nbits;
    bus(1'b1, 3'h0, 32'h29);
    wait_bits(30);
    chk(nbits, k);
    chk(32'(rx_active), 32'h0);
    oof_req <= 1'b0;
    wait_desc(7'h41);
    bus(1'b1, 3'h0, 32'h29);
    wait_bits(1);
    chk(32'(rx_active), 32'h1);
    // masked group: recovery still sets status but queues nothing
    bus(1'b1, 3'h0, 32'h11);
    oof_req <= 1'b1;
    wait_desc(7'h0b);
    oof_req <= 1'b0;
    wait_bits(20);
    chk(dq.size(), 0);
    rdchk(3'h2, 32'h6);
    complete_run();
  end
endmodule
`default_nettype wire
